// ===== hdl/req_fifo.sv
// Synchronous FIFO holding controller requests.
// Assumes one clock; out_data is valid while out_valid is high.
`timescale 1ns/1ps
`default_nettype none

module req_fifo #(
   parameter int WIDTH = 8,  // Entry width
   parameter int DEPTH = 16  // Entries, a power of two
) (
   input  wire logic             sys_clk_i,  // System clock
   input  wire logic             rstn_i,     // Async reset, active low
   input  wire logic             in_valid_i, // Entry offered
   output logic                  in_ready_o, // Room for an entry
   input  wire logic [WIDTH-1:0] in_data_i,  // Entry written
   output logic                  out_valid_o,// Entry waiting
   input  wire logic             out_ready_i,// Sink takes entry
   output logic [WIDTH-1:0]      out_data_o  // Oldest entry
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW:0] wr; // Write pointer with wrap bit
      logic [AW:0] rd; // Read pointer with wrap bit
   } fifo_s;

   fifo_s            st;          // Registered pointers
   fifo_s            next_st;     // Next pointers
   logic [WIDTH-1:0] mem [DEPTH]; // Entry storage, no reset needed
   logic             push;        // Entry written this cycle
   logic             pop;         // Entry read this cycle

   // Full when pointers differ only in the wrap bit
   assign in_ready_o  = !((st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]));
   assign out_valid_o = (st.wr != st.rd);
   assign out_data_o  = mem[st.rd[AW-1:0]];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // ----------------------------------------------------------------
   // Pointer update
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (push) next_st.wr = st.wr + 1'b1;
      if (pop) next_st.rd = st.rd + 1'b1;
   end

   // Pointers reset to empty
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Storage write
   always_ff @(posedge sys_clk_i) begin
      if (push) mem[st.wr[AW-1:0]] <= in_data_i;
   end

endmodule

`default_nettype wire

// ===== hdl/secded_memory_ecc_path.sv
// SECDED protection between a local bus master and a 144-bit memory
// controller: write encoder with request buffer, read decoder-correctors.
// Assumes all inputs come from logic on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Decode 72-bit codeword to 64-bit message
// - Decoder forms syndrome, passes it with message
// - Three read levels; parameter drops first
// - Output valid pulses once per read word, both messages together
// - Flags appear with output valid
// - Flags: none, single corrected, double; never both
// - Flip erroneous data bit; check bit errors pass
// - Double error leaves message untouched
// - Wider errors seen as single get corrected
// - Forward 24-bit burst address to controller
// - Encode 128-bit write data to 144 bits
// - Decode 144-bit read data with valid strobe
// - Requests taken only while ready is high
// - Low-half flags describe bits 63:0
// - High-half flags describe bits 127:64
// - Forward burst-begin strobe with first beat
// - Burst size forwarded, or fixed at one
// - Two messages coded separately, then joined
// - Controls follow encoder, held while controller busy
// - Read latency three, or two clocks
module secded_memory_ecc_path #(
   parameter bit REG_INPUT_DEC  = 1'b1, // Keep read input level
   parameter bit SIZE_FIXED_ONE = 1'b0  // Burst size tied to one
) (
   input  wire logic                          sys_clk_i,              // System clock
   input  wire logic                          rstn_i,                 // Async reset, active low
   input  wire logic [secded_pkg::ADDR_W-1:0] local_addr_i,           // Burst start address
   input  wire logic                          local_burstbegin_i,     // First beat of burst
   input  wire logic                          local_read_req_i,       // Read request
   input  wire logic                          local_write_req_i,      // Write request
   input  wire logic [secded_pkg::SIZE_W-1:0] local_size_i,           // Burst size
   input  wire logic [secded_pkg::LOCAL_W-1:0] local_wdata_i,         // Write data
   output logic                               local_ready_o,          // Request taken when high
   output logic [secded_pkg::LOCAL_W-1:0]     local_rdata_o,          // Corrected read data
   output logic                               local_rdata_valid_o,    // Read data valid
   output logic                               low_half_single_flag_o, // Bits 63:0 corrected
   output logic                               low_half_double_flag_o, // Bits 63:0 uncorrectable
   output logic                               high_half_single_flag_o,// Bits 127:64 corrected
   output logic                               high_half_double_flag_o,// Bits 127:64 uncorrectable
   output logic [secded_pkg::ADDR_W-1:0]      ecc_addr_o,             // Address to controller
   output logic                               ecc_burstbegin_o,       // Burst begin to controller
   output logic                               ecc_read_req_o,         // Read request to controller
   output logic                               ecc_write_req_o,        // Write request to controller
   output logic [secded_pkg::SIZE_W-1:0]      ecc_size_o,             // Burst size to controller
   output logic [secded_pkg::MEM_W-1:0]       ecc_wdata_o,            // Encoded write data
   input  wire logic                          ecc_ready_i,            // Controller can take request
   input  wire logic [secded_pkg::MEM_W-1:0]  ecc_rdata_i,            // Raw read codewords
   input  wire logic                          ecc_rdata_valid_i       // Read codewords valid
);

   // ----------------------------------------------------------------
   // Constants and state
   // ----------------------------------------------------------------
   localparam int RD_LAT = REG_INPUT_DEC ? secded_pkg::LAT_FULL : secded_pkg::LAT_SHORT;

   // Every register outside the request buffer lives here
   typedef struct packed {
      logic                               enc_v;  // Encoder stage full
      secded_pkg::mem_req_s               enc;    // Encoded request
      logic                               in_v;   // Read input level valid
      logic [secded_pkg::MEM_W-1:0]       in_cw;  // Read input codewords
      logic                               syn_v;  // Syndrome level valid
      secded_pkg::syn_s [secded_pkg::MSG_N-1:0]  syn; // Per-message syndrome
      logic                               out_v;  // Output level valid
      secded_pkg::corr_s [secded_pkg::MSG_N-1:0] out; // Per-message result
   } state_s;

   state_s st;      // Registered state
   state_s next_st; // Next state

   // Combinational helpers
   logic                                      fifo_in_ready; // Buffer has room
   logic                                      fifo_out_v;    // Request waiting
   secded_pkg::mem_req_s                      head;          // Oldest request
   logic [secded_pkg::MEM_W-1:0]              enc_cw;        // Encoded write word
   logic                                      dec_v;         // Decoder input valid
   logic [secded_pkg::MEM_W-1:0]              dec_cw;        // Decoder input word
   secded_pkg::syn_s [secded_pkg::MSG_N-1:0]  syn_calc;      // Fresh syndromes
   secded_pkg::corr_s [secded_pkg::MSG_N-1:0] corr_calc;     // Fresh corrections

   // ----------------------------------------------------------------
   // Write side handshake
   // ----------------------------------------------------------------
   // The encoder stage may load when empty or when it moves on.
   // Combinational ready saves a cycle of
   // back-pressure; the cost is a path
   // from the buffer's full flag to the
   // master.
   assign local_ready_o = !st.enc_v || fifo_in_ready;

   // ----------------------------------------------------------------
   // Read side input select
   // ----------------------------------------------------------------
   // Without the input level the decoder sees the controller directly.
   // That saves a clock of latency but
   // puts the syndrome logic right
   // behind the controller's flops.
   assign dec_v  = REG_INPUT_DEC ? st.in_v : ecc_rdata_valid_i;
   assign dec_cw = REG_INPUT_DEC ? st.in_cw : ecc_rdata_i;

   // ----------------------------------------------------------------
   // Per-message encode, decode and correct
   // ----------------------------------------------------------------
   for (genvar g = 0; g < secded_pkg::MSG_N; g++) begin : g_msg
      logic [secded_pkg::CODE_W-1:0] cw; // This message's codeword
      secded_pkg::syn_s              s;  // Registered syndrome

      assign cw = dec_cw[g*secded_pkg::CODE_W +: secded_pkg::CODE_W];
      assign s  = st.syn[g];

      // Each half of the local word is its own codeword
      assign enc_cw[g*secded_pkg::CODE_W +: secded_pkg::CODE_W] =
         secded_pkg::encode(local_wdata_i[g*secded_pkg::DATA_W +: secded_pkg::DATA_W]);

      // Recomputed check bits xor received ones give the syndrome
      assign syn_calc[g].syn  = secded_pkg::hamming_chk(cw[secded_pkg::DATA_W-1:0]) ^
                                cw[secded_pkg::PARITY_BIT-1:secded_pkg::DATA_W];
      assign syn_calc[g].perr = ^cw;
      assign syn_calc[g].msg  = cw[secded_pkg::DATA_W-1:0];

      // Odd parity means one error; check-bit positions give no mask.
      // Three flips can look like one:
      // the code cannot tell, so the
      // correction goes ahead anyway.
      assign corr_calc[g].single = s.perr;
      assign corr_calc[g].dbl    = !s.perr && (s.syn != '0);
      assign corr_calc[g].msg    = s.perr ? (s.msg ^ secded_pkg::data_mask(s.syn)) : s.msg;
   end

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;

      // Encoder stage loads whenever local_ready_o is high, request or not.
      // Fields are copied even when idle;
      // only enc_v says they mean anything.
      if (local_ready_o) begin
         next_st.enc_v           = local_read_req_i || local_write_req_i;
         next_st.enc.rd          = local_read_req_i;
         next_st.enc.wr          = local_write_req_i;
         next_st.enc.burst_begin = local_burstbegin_i;
         next_st.enc.size        = SIZE_FIXED_ONE ? secded_pkg::SIZE_ONE : local_size_i;
         next_st.enc.addr        = local_addr_i;
         next_st.enc.wdata       = enc_cw;
      end
      // Otherwise the stage holds while the buffer is full

      // Input level; constant zero when the level is removed
      next_st.in_v  = REG_INPUT_DEC && ecc_rdata_valid_i;
      next_st.in_cw = REG_INPUT_DEC ? ecc_rdata_i : '0;

      // Syndrome level takes a word only when one is valid
      next_st.syn_v = dec_v;
      if (dec_v) next_st.syn = syn_calc;

      // Output level: valid lasts one cycle per word
      next_st.out_v = st.syn_v;
      for (int g = 0; g < secded_pkg::MSG_N; g++) begin
         if (st.syn_v) begin
            next_st.out[g] = corr_calc[g];
         end else begin
            // Flags drop between words, data holds
            next_st.out[g].single = 1'b0;
            next_st.out[g].dbl    = 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Reset clears every valid and every flag at once.
   // Release is expected to be timed
   // to the clock by the system.
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Request buffer toward the controller
   // ----------------------------------------------------------------
   // Sixteen entries absorb controller stalls so the master keeps
   // streaming; back-pressure reaches it through local_ready_o.
   req_fifo #(
      .WIDTH ($bits(secded_pkg::mem_req_s)),
      .DEPTH (secded_pkg::FIFO_DEPTH)
   ) u_req_fifo (
      .sys_clk_i   (sys_clk_i),
      .rstn_i      (rstn_i),
      .in_valid_i  (st.enc_v),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (st.enc),
      .out_valid_o (fifo_out_v),
      .out_ready_i (ecc_ready_i),
      .out_data_o  (head)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Head entry stays in place until the controller is ready
   assign ecc_read_req_o   = fifo_out_v && head.rd;
   assign ecc_write_req_o  = fifo_out_v && head.wr;
   assign ecc_burstbegin_o = fifo_out_v && head.burst_begin;
   assign ecc_size_o       = head.size;
   assign ecc_addr_o       = head.addr;
   assign ecc_wdata_o      = head.wdata;

   // Halves rejoin in the order they were split.
   // Data holds between words; only
   // the strobe and flags say when
   // a word is new.
   assign local_rdata_o           = {st.out[1].msg, st.out[0].msg};
   assign local_rdata_valid_o     = st.out_v;
   assign low_half_single_flag_o  = st.out[0].single;
   assign low_half_double_flag_o  = st.out[0].dbl;
   assign high_half_single_flag_o = st.out[1].single;
   assign high_half_double_flag_o = st.out[1].dbl;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // The checks below watch the block's
   // ports and state.
   // Data checks look back by the read
   // latency, so they follow the
   // input level parameter.

   // Read-valid emerges exactly the read latency later
   AST_READ_LATENCY: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ecc_rdata_valid_i |-> ##RD_LAT local_rdata_valid_o)
      else $error("read valid not delivered at latency");

   // A valid never appears without a cause, so it is one pulse each
   AST_VALID_PULSE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      local_rdata_valid_o |-> $past(ecc_rdata_valid_i, RD_LAT))
      else $error("read valid without matching input");

   // Flags only ride on a valid word
   AST_FLAGS_WITH_VALID: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (low_half_single_flag_o || low_half_double_flag_o ||
       high_half_single_flag_o || high_half_double_flag_o) |-> local_rdata_valid_o)
      else $error("error flag outside read valid");

   // Single and double never together
   AST_FLAGS_EXCLUSIVE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !(low_half_single_flag_o && low_half_double_flag_o) &&
      !(high_half_single_flag_o && high_half_double_flag_o))
      else $error("single and double flag both high");

   // Without a single error the low message passes untouched
   AST_LOW_PASS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (local_rdata_valid_o && !low_half_single_flag_o) |->
      local_rdata_o[63:0] == $past(ecc_rdata_i[63:0], RD_LAT))
      else $error("low message altered without single error");

   // A single error changes at most one bit of the high message
   AST_HIGH_ONE_FLIP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (local_rdata_valid_o && high_half_single_flag_o) |->
      $countones(local_rdata_o[127:64] ^ $past(ecc_rdata_i[135:72], RD_LAT)) <= 1)
      else $error("correction changed more than one bit");

   // A stalled request keeps its address and data
   AST_HOLD_STALL: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ((ecc_write_req_o || ecc_read_req_o) && !ecc_ready_i) |=>
      ((ecc_write_req_o || ecc_read_req_o) && $stable(ecc_addr_o) && $stable(ecc_wdata_o)))
      else $error("request changed while controller busy");

   // Each written codeword carries even overall parity
   AST_WRITE_PARITY: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ecc_write_req_o |-> (^ecc_wdata_o[71:0] == 1'b0) && (^ecc_wdata_o[143:72] == 1'b0))
      else $error("encoded write word has odd parity");

   // A taken write reaches the controller request line within 21 cycles
   AST_WRITE_REACHES: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (local_write_req_i && local_ready_o && ecc_ready_i) |=> ##[0:20] ecc_write_req_o)
      else $error("accepted write never forwarded");

   // Burst begin never travels alone
   AST_BURST_WITH_REQ: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      ecc_burstbegin_o |-> (ecc_read_req_o || ecc_write_req_o))
      else $error("burst begin without request");

   // Tied size reads one on every read request
   AST_SIZE_TIED: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (SIZE_FIXED_ONE && ecc_read_req_o) |-> (ecc_size_o == secded_pkg::SIZE_ONE))
      else $error("burst size not tied");

   // An empty stage always takes
   AST_READY_EMPTY: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      !st.enc_v |-> local_ready_o)
      else $error("ready low with empty stage");

   // No single error: high half raw
   AST_HIGH_PASS: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (local_rdata_valid_o && !high_half_single_flag_o) |->
      local_rdata_o[127:64] == $past(ecc_rdata_i[135:72], RD_LAT))
      else $error("high message altered");

   // Low correction flips at most one bit
   AST_LOW_ONE_FLIP: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
      (local_rdata_valid_o && low_half_single_flag_o) |->
      $countones(local_rdata_o[63:0] ^ $past(ecc_rdata_i[63:0], RD_LAT)) <= 1)
      else $error("low correction too wide");

   // Reset keeps valid and flags low
   AST_RESET_CLEAR: assert property (@(posedge sys_clk_i)
      !rstn_i |-> !(local_rdata_valid_o || low_half_single_flag_o ||
      low_half_double_flag_o || high_half_single_flag_o || high_half_double_flag_o))
      else $error("valid or flag high in reset");

endmodule

`default_nettype wire

// ===== include/secded_pkg.sv
// Shared constants, carriers and code functions for the SECDED path.
// Assumes one system clock; included before every design file.
package secded_pkg;

   // ----------------------------------------------------------------
   // Widths and code layout
   // ----------------------------------------------------------------
   localparam int DATA_W     = 64;  // Message bits per codeword
   localparam int CHK_W      = 7;   // Hamming check bits
   localparam int CODE_W     = 72;  // Data, check bits, overall parity
   localparam int PARITY_BIT = 71;  // Overall parity position
   localparam int MSG_N      = 2;   // Messages per local word
   localparam int ADDR_W     = 24;  // Burst start address
   localparam int SIZE_W     = 2;   // Burst size count
   localparam int LOCAL_W    = 128; // Local data bus
   localparam int MEM_W      = 144; // Controller data bus
   localparam int FIFO_DEPTH = 16;  // Request buffer entries
   localparam int FIRST_POS  = 3;   // First Hamming position of data
   localparam int LAT_FULL   = 3;   // Read latency, input level kept
   localparam int LAT_SHORT  = 2;   // Read latency, input level removed
   localparam logic [SIZE_W-1:0] SIZE_ONE = 2'h1; // Fixed burst size

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic              rd;          // Read request
      logic              wr;          // Write request
      logic              burst_begin; // First beat of burst
      logic [SIZE_W-1:0] size;        // Burst size
      logic [ADDR_W-1:0] addr;        // Burst start address
      logic [MEM_W-1:0]  wdata;       // Two encoded codewords
   } mem_req_s;

   typedef struct packed {
      logic [CHK_W-1:0]  syn;  // Syndrome
      logic              perr; // Overall parity mismatch
      logic [DATA_W-1:0] msg;  // Received message
   } syn_s;

   typedef struct packed {
      logic              single; // One error, corrected
      logic              dbl;    // Two errors, left alone
      logic [DATA_W-1:0] msg;    // Corrected message
   } corr_s;

   // ----------------------------------------------------------------
   // Code functions
   // ----------------------------------------------------------------
   // Data bit k sits at the k-th position that is not a power of two,
   // so the xor of positions of set bits gives the check bits.
   function automatic logic [CHK_W-1:0] hamming_chk(input logic [DATA_W-1:0] d);
      logic [CHK_W-1:0] c;
      int               k;
      c = '0;
      k = 0;
      for (int p = FIRST_POS; p < CODE_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (d[k]) c = c ^ CHK_W'(p);
            k++;
         end
      end
      return c;
   endfunction

   // One-hot mask of the data bit that a syndrome points at, or zero
   function automatic logic [DATA_W-1:0] data_mask(input logic [CHK_W-1:0] syn);
      logic [DATA_W-1:0] m;
      int                k;
      m = '0;
      k = 0;
      for (int p = FIRST_POS; p < CODE_W; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (CHK_W'(p) == syn) m[k] = 1'b1;
            k++;
         end
      end
      return m;
   endfunction

   // Codeword: parity on top, check bits, then the message
   function automatic logic [CODE_W-1:0] encode(input logic [DATA_W-1:0] d);
      logic [CHK_W-1:0] c;
      c = hamming_chk(d);
      return {^{c, d}, c, d};
   endfunction

endpackage

// ===== verification/mem_ctrl_model.sv
// Memory controller stand-in: stores codewords, answers a read one cycle later.
// Assumes requests from the ECC path on the same clock; the bench sets stall and error mask.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
   input  wire logic         sys_clk_i, // System clock
   input  wire logic         rstn_i,    // Async reset, active low
   input  wire logic         stall_i,   // Hold off requests
   input  wire logic [143:0] flip_i,    // Error mask on read data
   input  wire logic         rd_i,      // Read request
   input  wire logic         wr_i,      // Write request
   input  wire logic [23:0]  addr_i,    // Burst address
   input  wire logic [143:0] wdata_i,   // Codewords written
   output logic              ready_o,   // Can take a request
   output logic [143:0]      rdata_o,   // Codewords read
   output logic              rvalid_o   // Read data valid
);
   logic [143:0] mem [16]; // Small store, address wraps at 16
   // Requests count only while ready is high
   assign ready_o = !stall_i;
   // Storage and read return
   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rvalid_o <= 1'b0;
         rdata_o  <= '0;
      end else begin
         rvalid_o <= rd_i && ready_o;
         // Idle bus toggles so stale data never passes for a codeword
         rdata_o <= (rd_i && ready_o) ? (mem[addr_i[3:0]] ^ flip_i) : ~rdata_o;
         if (wr_i && ready_o) begin
            mem[addr_i[3:0]] <= wdata_i;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/secded_memory_ecc_path_test.sv
// Self-checking bench for the SECDED path: stalled writes, buffer fill, error injection.
// Assumes the controller stand-in mem_ctrl_model on the far side.
`timescale 1ns/1ps
`default_nettype none
module secded_memory_ecc_path_test;
   logic         sys_clk_i = 1'b0;               // System clock
   logic         rstn_i = 1'b0;                  // Reset, active low
   logic         rd = 1'b0, wr = 1'b0, bb = 1'b0; // Request strobes
   logic         stall = 1'b0;                   // Controller busy
   logic [23:0]  addr = '0, eaddr;               // Burst addresses
   logic [1:0]   size = '0, esz;                 // Burst sizes
   logic [127:0] wdata = '0, lrdata;             // Local words
   logic [143:0] flip = '0, ewd, mrdata;         // Error mask, codewords
   logic [3:0]   fl;                             // Low single, low double, high single, high double
   logic         ready, rvalid, erd, ewr, ebb, mready, mrvalid;
   int           n_fail = 0, tests_run = 0, n;
   localparam logic [127:0] D = 128'h0123456789abcdef_fedcba9876543210;
   always #10 sys_clk_i = ~sys_clk_i;
   secded_memory_ecc_path dut (.sys_clk_i, .rstn_i, .local_addr_i(addr), .local_burstbegin_i(bb),
      .local_read_req_i(rd), .local_write_req_i(wr), .local_size_i(size), .local_wdata_i(wdata),
      .local_ready_o(ready), .local_rdata_o(lrdata), .local_rdata_valid_o(rvalid),
      .low_half_single_flag_o(fl[3]), .low_half_double_flag_o(fl[2]), .high_half_single_flag_o(fl[1]),
      .high_half_double_flag_o(fl[0]), .ecc_addr_o(eaddr), .ecc_burstbegin_o(ebb), .ecc_read_req_o(erd),
      .ecc_write_req_o(ewr), .ecc_size_o(esz), .ecc_wdata_o(ewd), .ecc_ready_i(mready),
      .ecc_rdata_i(mrdata), .ecc_rdata_valid_i(mrvalid));
   mem_ctrl_model ctrl (.sys_clk_i, .rstn_i, .stall_i(stall), .flip_i(flip), .rd_i(erd), .wr_i(ewr),
      .addr_i(eaddr), .wdata_i(ewd), .ready_o(mready), .rdata_o(mrdata), .rvalid_o(mrvalid));
   // Own codeword model: parity on top, Hamming check bits, message
   function automatic logic [71:0] cw(input logic [63:0] d);
      logic [6:0] c;
      int         k;
      c = '0;
      k = 0;
      for (int p = 3; p < 72; p++) begin
         if ((p & (p - 1)) != 0) begin
            if (d[k]) c = c ^ 7'(p);
            k++;
         end
      end
      return {^{c, d}, c, d};
   endfunction
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic cmp(input logic [143:0] got, input logic [143:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Bounded wait for an edge where the sampled flag is high
   task automatic wait_hi(ref logic f);
      n = 0;
      do begin @(posedge sys_clk_i); n++; end while (f !== 1'b1 && n < 50);
      if (n >= 50) begin n_fail++; tally_and_finish(); end
   endtask
   // Request held until taken with ready high
   task automatic req(input logic r, input logic [23:0] a, input logic [127:0] d);
      rd <= r; wr <= !r; addr <= a; wdata <= d; bb <= 1'b1; size <= 2'h2;
      wait_hi(ready);
      rd <= 1'b0; wr <= 1'b0; bb <= 1'b0;
   endtask
   // Read, then word, flags, and a one-cycle strobe
   task automatic rd_chk(input logic [127:0] d, input logic [3:0] f);
      req(1'b1, 24'h000005, '0);
      wait_hi(rvalid);
      cmp({16'h0, lrdata}, {16'h0, d});
      cmp({140'h0, fl}, {140'h0, f});
      @(posedge sys_clk_i);
      cmp({139'h0, rvalid, fl}, '0);
   endtask
   initial begin
      repeat (3000) @(posedge sys_clk_i);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      @(posedge sys_clk_i);
      // Busy controller: the request stands with encoded fields
      stall <= 1'b1;
      req(1'b0, 24'h000005, D);
      repeat (4) @(posedge sys_clk_i);
      cmp({ewr, ebb, esz, eaddr}, {1'b1, 1'b1, 2'h2, 24'h000005});
      cmp(ewd, {cw(D[127:64]), cw(D[63:0])});
      // Fill stage and buffer until refused
      n = 1;
      wr <= 1'b1;
      bb <= 1'b1;
      repeat (30) begin @(posedge sys_clk_i); if (ready) n++; end
      cmp(n, 17);
      wr <= 1'b0;
      stall <= 1'b0;
      repeat (30) @(posedge sys_clk_i);
      cmp(ewr, 1'b0);
      rd_chk(D, 4'h0);
      flip <= 144'h1;
      rd_chk(D, 4'h8);
      flip <= 144'h1 << 136;
      rd_chk(D, 4'h2);
      flip <= 144'h3;
      rd_chk(D ^ 128'h3, 4'h4);
      flip <= 144'h7;
      rd_chk(D ^ 128'h7, 4'h8);
      flip <= (144'h3 << 77) | 144'h400;
      rd_chk(D ^ (128'h60 << 64), 4'h9);
      tally_and_finish();
   end
endmodule
`default_nettype wire
